// ==== shared/pcb_pkg.sv ====
`default_nettype none
package pcb_pkg;
   // register byte offsets on the local register port
   localparam logic [7:0] PCB_OFF_CFG = 8'h00;
   localparam logic [7:0] PCB_OFF_STAT = 8'h04;
   localparam logic [7:0] PCB_OFF_MASK = 8'h08;
   // pin configuration field positions
   localparam int PCB_BIT_OD = 8;
   localparam int PCB_BIT_EDGE = 7;
   localparam int PCB_DET_HI = 6;
   localparam int PCB_DET_LO = 4;
   localparam int PCB_PWR_HI = 3;
   localparam int PCB_PWR_LO = 2;
   // reset values: detection 0000 means low level sensitive
   localparam logic [6:0] PCB_CFG_RST = 7'h00;
   localparam logic [1:0] PCB_STAT_RST = 2'h0;
   localparam logic [1:0] PCB_MASK_RST = 2'h0;
   // status and mask bit positions
   localparam int PCB_ST_EVT = 0;
   localparam int PCB_ST_GATE = 1;
   // power well select codes
   localparam logic [1:0] PCB_PWR_STANDBY = 2'h0;
   localparam logic [1:0] PCB_PWR_MAIN = 2'h1;
   // {edge enable, detection} codes
   localparam logic [3:0] PCB_DET_LOW = 4'h0;
   localparam logic [3:0] PCB_DET_HIGH = 4'h1;
   localparam logic [3:0] PCB_DET_OFF = 4'h4;
   localparam logic [3:0] PCB_DET_RISE = 4'hD;
   localparam logic [3:0] PCB_DET_FALL = 4'hE;
   localparam logic [3:0] PCB_DET_BOTH = 4'hF;

   typedef enum {
      PCB_M_NONE, PCB_M_LOW, PCB_M_HIGH, PCB_M_RISE, PCB_M_FALL, PCB_M_BOTH
   } pcb_mode_e;

   // detect code to mode; reserved codes raise nothing
   function automatic pcb_mode_e pcb_decode(input logic [3:0] code);
      pcb_mode_e m;
      m = PCB_M_NONE;
      case (code)
         PCB_DET_LOW: m = PCB_M_LOW;
         PCB_DET_HIGH: m = PCB_M_HIGH;
         PCB_DET_RISE: m = PCB_M_RISE;
         PCB_DET_FALL: m = PCB_M_FALL;
         PCB_DET_BOTH: m = PCB_M_BOTH;
         default: m = PCB_M_NONE;
      endcase
      return m;
   endfunction

   // true for the edge triggered modes only
   function automatic logic pcb_is_edge(input logic [3:0] code);
      pcb_mode_e m;
      m = pcb_decode(code);
      return (m == PCB_M_RISE) || (m == PCB_M_FALL) || (m == PCB_M_BOTH);
   endfunction
endpackage
`default_nettype wire

// ==== shared/pcb_evt_if.sv ====
`default_nettype none
interface pcb_evt_if;
   logic pad_in;
   logic invert;
   logic analog;
   logic [3:0] det_code;
   logic event_pulse;
   modport ctrl (output pad_in, output invert, output analog, output det_code,
      input event_pulse);
   modport det (input pad_in, input invert, input analog, input det_code,
      output event_pulse);
endinterface
`default_nettype wire

// ==== hdl/pcb_event_detect.sv ====
`default_nettype none
module pcb_event_detect (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // detection channel
   pcb_evt_if.det evt
);
   import pcb_pkg::*;

   logic sync_a;
   logic sync_b;
   logic prev_sense;
   logic fill_a;
   logic sync_ok; // sync_b holds a real pin sample
   logic prev_ok; // prev_sense holds a real pin sample
   logic event_q;
   pcb_mode_e mode;
   wire logic sense;
   wire logic rise;
   wire logic fall;
   logic next_event;

   // (R13) sense inversion for alternate functions
   assign sense = sync_b ^ evt.invert;
   assign rise = sense & ~prev_sense & prev_ok;
   assign fall = ~sense & prev_sense & prev_ok;
   assign mode = pcb_decode(evt.det_code);
   assign evt.event_pulse = event_q;

   // (R14) two flop sync of the pin input
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev_sense <= 1'b0;
      end else begin
         sync_a <= evt.pad_in;
         sync_b <= sync_a;
         prev_sense <= sense;
      end
   end

   // (R14) fill flags: the reset zeros in the sync flops are not pin
   // samples, so a pulled-up pad would otherwise show a false event
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fill_a <= 1'b0;
         sync_ok <= 1'b0;
         prev_ok <= 1'b0;
      end else begin
         fill_a <= 1'b1;
         sync_ok <= fill_a;
         prev_ok <= sync_ok;
      end
   end

   // (R11) event per detect mode, (R05) input sampled whatever the mux
   always_comb begin
      next_event = 1'b0;
      case (mode)
         PCB_M_LOW: next_event = ~sense;
         PCB_M_HIGH: next_event = sense;
         PCB_M_RISE: next_event = rise;
         PCB_M_FALL: next_event = fall;
         PCB_M_BOTH: next_event = rise | fall;
         default: next_event = 1'b0;
      endcase
      // (R06) analog functions give no input sample; nor does a filling sync
      if (evt.analog || !sync_ok) begin
         next_event = 1'b0;
      end
   end

   // event register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         event_q <= 1'b0;
      end else begin
         event_q <= next_event;
      end
   end

   a_rise_event: assert property (@(posedge clock) disable iff (!rst_n) // (R14)
      (mode == PCB_M_RISE && !evt.analog && rise) |=> event_q)
      else $error("rising edge gave no event");
   a_edge_single: assert property (@(posedge clock) disable iff (!rst_n) // (R14)
      (mode == PCB_M_BOTH && event_q && $stable(sense)) |=> !event_q)
      else $error("edge event longer than one cycle");
   a_analog_quiet: assert property (@(posedge clock) disable iff (!rst_n) // (R06)
      evt.analog |=> !event_q)
      else $error("event on analog function");
   a_low_level: assert property (@(posedge clock) disable iff (!rst_n) // (R11)
      (mode == PCB_M_LOW && !evt.analog && sync_ok) |=> (event_q == !$past(sense)))
      else $error("low level event wrong");
   a_off_quiet: assert property (@(posedge clock) disable iff (!rst_n) // (R11)
      (mode == PCB_M_NONE) |=> !event_q)
      else $error("event while detection disabled");
endmodule
`default_nettype wire

// ==== hdl/pcb_pin_ctrl.sv ====
// Overview of operation
// (R01) Configuration bit 8 picks push-pull (0) or open-drain (1) output drive.
// (R02) The drive style applies to every muxed function unless the pin is exempt.
// (R03) Configuration bit 7 enables edge detection for the pin.
// (R04) Bits 6:4 with the edge enable choose which pin condition raises the event.
// (R05) The pin input is sampled for events even when an alternate function owns it.
// (R06) Analog functions provide no input sample, so they raise no events.
// (R07) Bits 3:2 select an emulated power well; the pin tristates while it is off.
// (R08) Well code 00 tristates the output while the standby well good signal is low.
// (R09) Well code 01 tristates the output while main well power good is low.
// (R10) Firmware must not write the reserved well codes 10 and 11.
// (R11) Codes 0000 low, 0001 high, 0100 off, 1101 rise, 1110 fall, 1111 either edge.
// (R12) Only edge modes may request a ring wake, and only with the aggregator enabled.
// (R13) Polarity set with a non-GPIO mux selection inverts the detection sense.
// (R14) Edges are found after a two flop sync and give a one cycle event each.
// (R15) Open-drain drives low for a zero and releases the pad for a one.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none
module pcb_pin_ctrl #(
   parameter bit OD_EXEMPT = 1'b0
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // selected function and neighbouring fields
   input wire logic [1:0] mux_sel,
   input wire logic polarity,
   input wire logic func_out,
   input wire logic func_oe,
   input wire logic func_analog,
   // power well indications
   input wire logic standby_well_good,
   input wire logic main_well_power_good,
   // pad
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   // aggregator side
   input wire logic agg_irq_enable,
   output logic pin_event,
   output logic ring_wake_req,
   output logic irq
);
   import pcb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // only bits 8:2 are stored here; the other fields of the pin word sit in
   // neighbouring blocks, so they read back as zero from this port
   logic [6:0] cfg; // configuration bits 8:2
   logic [1:0] status;
   logic [1:0] mask;
   logic gated_q;

   wire logic od_bit;
   wire logic edge_en;
   wire logic [2:0] det_field;
   wire logic [3:0] det_code;
   wire logic [1:0] pwr_sel;

   // field extraction from the stored bits 8:2
   assign od_bit = cfg[PCB_BIT_OD - PCB_PWR_LO];
   assign edge_en = cfg[PCB_BIT_EDGE - PCB_PWR_LO];
   assign det_field = cfg[PCB_DET_HI - PCB_PWR_LO:PCB_DET_LO - PCB_PWR_LO];
   assign det_code = {edge_en, det_field};
   assign pwr_sel = cfg[PCB_PWR_HI - PCB_PWR_LO:0];

   // address decode
   wire logic sel_cfg;
   wire logic sel_stat;
   wire logic sel_mask;
   assign sel_cfg = (reg_addr == PCB_OFF_CFG);
   assign sel_stat = (reg_addr == PCB_OFF_STAT);
   assign sel_mask = (reg_addr == PCB_OFF_MASK);

   // configuration and mask writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfg <= PCB_CFG_RST;
         mask <= PCB_MASK_RST;
      end else if (reg_wr && sel_cfg) begin
         cfg <= reg_wdata[PCB_BIT_OD:PCB_PWR_LO];
      end else if (reg_wr && sel_mask) begin
         mask <= reg_wdata[1:0];
      end
   end

   // idle cycles read zero, so a stale word never lingers on the shared bus
   // read data, one cycle after the strobe, zero otherwise
   wire logic [31:0] rd_word;
   assign rd_word = sel_cfg ? {23'h000000, cfg, 2'h0} :
                    sel_stat ? {30'h00000000, status} :
                    sel_mask ? {30'h00000000, mask} : 32'h00000000;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rd ? rd_word : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event detection

   pcb_evt_if evt ();
   wire logic det_event;

   // (R05) input path always fed, whatever the mux
   assign evt.pad_in = pad_in;
   // (R13) invert only for alternate functions
   assign evt.invert = polarity && (mux_sel != 2'h0);
   assign evt.analog = func_analog;
   // (R03) edge enable joins the detection field
   assign evt.det_code = det_code;
   assign det_event = evt.event_pulse;

   // the detector sees the raw pad level, so alternate functions raise events
   // too; polarity is applied there to the synchronised sample
   // (R04) detector chooses the raising condition
   pcb_event_detect u_det (
      .clock(clock),
      .rst_n(rst_n),
      .evt(evt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pad drive and power gating

   wire logic od_eff;
   wire logic gated;
   logic next_pad_oe;
   logic next_pad_out;

   // an exempt pin keeps push-pull drive whatever the stored style bit says
   // (R02) one drive style for all functions unless exempt
   assign od_eff = od_bit && !OD_EXEMPT;

   // gating follows the well levels through the pad register, so a pad may
   // still drive for one cycle after its well is reported off
   // (R07) selected well off tristates; reserved codes never gate
   assign gated = ((pwr_sel == PCB_PWR_STANDBY) && !standby_well_good) ||
                  ((pwr_sel == PCB_PWR_MAIN) && !main_well_power_good);

   // open drain never drives a one: the high level is left to the board pull-up
   // (R01) push-pull drives both levels, (R15) open drain only pulls low
   always_comb begin
      next_pad_out = func_out;
      next_pad_oe = func_oe;
      if (od_eff) begin
         next_pad_out = 1'b0;
         next_pad_oe = func_oe && !func_out;
      end
      // (R08) (R09) well loss wins over any drive
      if (gated) begin
         next_pad_oe = 1'b0;
      end
   end

   // pad registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         gated_q <= 1'b0;
      end else begin
         pad_out <= next_pad_out;
         pad_oe <= next_pad_oe;
         gated_q <= gated;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, mask and outputs

   wire logic [1:0] st_set;
   wire logic [1:0] st_clr;
   wire logic [1:0] next_status;
   wire logic edge_mode;

   // status bit 1 marks the moment the pad became gated, not the level, so
   // firmware gets one sticky report per well loss
   assign st_set = {gated && !gated_q, det_event};
   assign st_clr = (reg_wr && sel_stat) ? reg_wdata[1:0] : 2'h0;
   // set wins over a clear in the same cycle
   assign next_status = (status & ~st_clr) | st_set;
   assign edge_mode = pcb_is_edge(det_code);

   // sticky status
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status <= PCB_STAT_RST;
      end else begin
         status <= next_status;
      end
   end

   // irq and wake are built from the next status so they rise with the sticky
   // bit and never lag it by a cycle
   // irq level, event copy and ring wake request
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq <= 1'b0;
         pin_event <= 1'b0;
         ring_wake_req <= 1'b0;
      end else begin
         irq <= |(next_status & mask);
         pin_event <= det_event;
         // (R12) wake only from edge modes with the aggregator enabled
         ring_wake_req <= edge_mode && agg_irq_enable && next_status[PCB_ST_EVT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_od_release: assert property (@(posedge clock) disable iff (!rst_n) // (R15)
      (od_eff && func_out) |=> !pad_oe)
      else $error("open drain drove a one");
   a_od_low: assert property (@(posedge clock) disable iff (!rst_n) // (R15)
      (od_eff && func_oe && !func_out && !gated) |=> (pad_oe && !pad_out))
      else $error("open drain failed to pull low");
   a_pp_drive: assert property (@(posedge clock) disable iff (!rst_n) // (R01)
      (!od_bit && func_oe && !gated) |=> (pad_oe && pad_out == $past(func_out)))
      else $error("push pull drive wrong");
   a_well_standby: assert property (@(posedge clock) disable iff (!rst_n) // (R08)
      (pwr_sel == PCB_PWR_STANDBY && !standby_well_good) |=> !pad_oe)
      else $error("pad driven with standby well off");
   a_well_main: assert property (@(posedge clock) disable iff (!rst_n) // (R09)
      (pwr_sel == PCB_PWR_MAIN && !main_well_power_good) |=> !pad_oe)
      else $error("pad driven with main well off");
   a_event_sticky: assert property (@(posedge clock) disable iff (!rst_n) // (R04)
      det_event |=> status[PCB_ST_EVT])
      else $error("event lost from status");
   a_wake_edge_only: assert property (@(posedge clock) disable iff (!rst_n) // (R12)
      (!edge_mode || !agg_irq_enable) |=> !ring_wake_req)
      else $error("wake request outside edge mode");
   a_irq_masked: assert property (@(posedge clock) disable iff (!rst_n) // (R11)
      (mask == 2'h0 && $stable(mask)) |=> !irq)
      else $error("interrupt with all masked");

   // register port and configuration fields
   a_cfg_od_write: assert property (@(posedge clock) disable iff (!rst_n) // (R01)
      (reg_wr && sel_cfg) |=> (od_bit == $past(reg_wdata[PCB_BIT_OD])))
      else $error("drive style bit not written");
   a_cfg_edge_write: assert property (@(posedge clock) disable iff (!rst_n) // (R03)
      (reg_wr && sel_cfg) |=> (edge_en == $past(reg_wdata[PCB_BIT_EDGE])))
      else $error("edge enable bit not written");
   a_cfg_det_write: assert property (@(posedge clock) disable iff (!rst_n) // (R04)
      (reg_wr && sel_cfg) |=> (det_field == $past(reg_wdata[PCB_DET_HI:PCB_DET_LO])))
      else $error("detection field not written");
   a_cfg_well_write: assert property (@(posedge clock) disable iff (!rst_n) // (R07)
      (reg_wr && sel_cfg) |=> (pwr_sel == $past(reg_wdata[PCB_PWR_HI:PCB_PWR_LO])))
      else $error("well field not written");
   a_cfg_readback: assert property (@(posedge clock) disable iff (!rst_n) // (R01)
      (reg_rd && sel_cfg) |=> (reg_rdata[PCB_BIT_OD:PCB_PWR_LO] == $past(cfg)))
      else $error("configuration read back wrong");
   a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n) // (R04)
      !reg_rd |=> (reg_rdata == 32'h00000000))
      else $error("read data outside a read cycle");

   // pad drive for every function and well state
   a_pp_low: assert property (@(posedge clock) disable iff (!rst_n) // (R01)
      (!od_eff && func_oe && !func_out && !gated) |=> (pad_oe && !pad_out))
      else $error("push pull failed to drive low");
   a_pp_high: assert property (@(posedge clock) disable iff (!rst_n) // (R01)
      (!od_eff && func_oe && func_out && !gated) |=> (pad_oe && pad_out))
      else $error("push pull failed to drive high");
   a_no_request: assert property (@(posedge clock) disable iff (!rst_n) // (R01)
      !func_oe |=> !pad_oe)
      else $error("pad driven without a request");
   a_od_out_zero: assert property (@(posedge clock) disable iff (!rst_n) // (R15)
      od_eff |=> !pad_out)
      else $error("open drain data not low");
   a_od_any_func: assert property (@(posedge clock) disable iff (!rst_n) // (R02)
      (od_eff && (mux_sel != 2'h0) && func_out) |=> !pad_oe)
      else $error("alternate function drove a one in open drain");
   a_gate_wins: assert property (@(posedge clock) disable iff (!rst_n) // (R07)
      gated |=> !pad_oe)
      else $error("pad driven while its well is off");

   // event, status, interrupt and wake paths
   a_event_copy: assert property (@(posedge clock) disable iff (!rst_n) // (R14)
      1'b1 |=> (pin_event == $past(det_event)))
      else $error("pin event does not follow the detector");
   a_gate_status: assert property (@(posedge clock) disable iff (!rst_n) // (R07)
      (gated && !gated_q) |=> status[PCB_ST_GATE])
      else $error("well loss not recorded");
   a_clear_works: assert property (@(posedge clock) disable iff (!rst_n) // (R04)
      (reg_wr && sel_stat && reg_wdata[PCB_ST_EVT] && !det_event) |=> !status[PCB_ST_EVT])
      else $error("event status not cleared");
   a_irq_level: assert property (@(posedge clock) disable iff (!rst_n) // (R04)
      irq == |(status & $past(mask)))
      else $error("interrupt level does not match status");
   a_wake_needs_event: assert property (@(posedge clock) disable iff (!rst_n) // (R12)
      ring_wake_req |-> status[PCB_ST_EVT])
      else $error("wake request without a pending event");
   a_wake_on_edge: assert property (@(posedge clock) disable iff (!rst_n) // (R12)
      (edge_mode && agg_irq_enable && det_event) |=> ring_wake_req)
      else $error("edge event gave no wake request");
endmodule
`default_nettype wire

// ==== verification/pcb_pad_model.sv ====
`default_nettype none
module pcb_pad_model (
   // design side of the pad
   input wire logic pad_out,
   input wire logic pad_oe,
   // outside driver on the board
   input wire logic ext_drive,
   input wire logic ext_level,
   // level seen at the pad input
   output logic pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   // released pad floats high
   // design driver first, then the board driver, else the board pull-up
   assign pad_in = pad_oe ? pad_out : (ext_drive ? ext_level : 1'b1);
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pcb_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [1:0] mux_sel = 2'h0;
   logic polarity = 1'b0, func_out = 1'b0, func_oe = 1'b0, func_analog = 1'b0;
   logic standby_well_good = 1'b1, main_well_power_good = 1'b1, agg_irq_enable = 1'b0;
   logic ext_drive = 1'b1, ext_level = 1'b1, cnt_on = 1'b0;
   logic pad_in, pad_out, pad_oe, pin_event, ring_wake_req, irq;
   logic [31:0] n_evt = 32'h0;
   int n_mismatch = 0;
   int checked = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // pad cases
   // {od, well, standby good, main good, out, oe, expected oe, expected out}
   logic [8:0] pad_tab [8] = '{9'b000111111, 9'b000110110, 9'b100111100, 9'b100110110,
      9'b000011101, 9'b000101111, 9'b001101101, 9'b001011111};
   // detect cases
   // {code, mux, polarity, analog, aggregator on, events in window, wake at end}
   logic [13:0] evt_tab [12] = '{14'b0000_00_0_0_1_1100_0, 14'b0001_00_0_0_1_1000_0,
      14'b0100_00_0_0_1_0000_0, 14'b1110_00_0_0_1_0001_1, 14'b1111_00_0_0_1_0010_1,
      14'b0010_00_0_0_1_0000_0, 14'b0001_01_1_0_1_1100_0, 14'b0001_00_1_0_1_1000_0,
      14'b0001_10_0_1_1_0000_0, 14'b1101_11_0_0_0_0001_0, 14'b1101_01_1_0_1_0001_1,
      14'b1101_00_0_0_1_0001_1};
   ////////////////////////////////////////////////////////////////////////////////
   // clock and design
   initial forever #10 clock = ~clock;
   pcb_pin_ctrl dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mux_sel(mux_sel), .polarity(polarity), .func_out(func_out), .func_oe(func_oe),
      .func_analog(func_analog), .standby_well_good(standby_well_good),
      .main_well_power_good(main_well_power_good), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .agg_irq_enable(agg_irq_enable), .pin_event(pin_event),
      .ring_wake_req(ring_wake_req), .irq(irq));
   pcb_pad_model pad_u (.pad_out(pad_out), .pad_oe(pad_oe), .ext_drive(ext_drive),
      .ext_level(ext_level), .pad_in(pad_in));
   // counts event cycles inside a window
   always @(posedge clock) begin
      if (!cnt_on) n_evt <= 32'h0;
      else if (pin_event === 1'b1) n_evt <= n_evt + 32'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // checking and bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("mismatches %0d, checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   // one high pulse of eight cycles inside a twenty cycle window
   task automatic run_evt(input logic [13:0] e);
      @(posedge clock);
      ext_level <= 1'b0;
      mux_sel <= e[9:8];
      polarity <= e[7];
      func_analog <= e[6];
      agg_irq_enable <= e[5];
      wr(PCB_OFF_CFG, {24'h0, e[13:10], 4'h0});
      repeat (6) @(posedge clock);
      wr(PCB_OFF_STAT, 32'h3);
      @(posedge clock);
      cnt_on <= 1'b1;
      ext_level <= 1'b1;
      repeat (8) @(posedge clock);
      ext_level <= 1'b0;
      repeat (12) @(posedge clock);
      cnt_on <= 1'b0;
      #1 check(n_evt, {28'h0, e[4:1]});
      check({31'h0, ring_wake_req}, {31'h0, e[0]});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      conclude();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      rd(PCB_OFF_CFG, 32'h0);
      rd(PCB_OFF_STAT, 32'h0);
      rd(PCB_OFF_MASK, 32'h0);
      wr(PCB_OFF_CFG, 32'hFFFF_FFF3); // well code kept at 00
      wr(8'h0C, 32'h0);
      rd(8'h0C, 32'h0);
      rd(PCB_OFF_CFG, 32'h0000_01F0);
      ext_drive <= 1'b0;
      foreach (pad_tab[i]) begin
         @(posedge clock);
         mux_sel <= {2{pad_tab[i][8]}};
         standby_well_good <= pad_tab[i][5];
         main_well_power_good <= pad_tab[i][4];
         func_out <= pad_tab[i][3];
         func_oe <= pad_tab[i][2];
         wr(PCB_OFF_CFG, {23'h0, pad_tab[i][8], 4'h0, pad_tab[i][7:6], 2'h0});
         repeat (2) @(posedge clock);
         #1 check({30'h0, pad_oe, pad_out}, {30'h0, pad_tab[i][1:0]});
      end
      func_oe <= 1'b0;
      ext_drive <= 1'b1;
      standby_well_good <= 1'b1;
      main_well_power_good <= 1'b1;
      foreach (evt_tab[i]) run_evt(evt_tab[i]);
      check({31'h0, irq}, 32'h0);
      rd(PCB_OFF_STAT, 32'h1);
      wr(PCB_OFF_MASK, 32'h1);
      repeat (2) @(posedge clock);
      #1 check({31'h0, irq}, 32'h1);
      wr(PCB_OFF_STAT, 32'h1);
      repeat (2) @(posedge clock);
      #1 check({30'h0, irq, ring_wake_req}, 32'h0);
      func_oe <= 1'b1;
      standby_well_good <= 1'b0;
      repeat (3) @(posedge clock);
      wr(PCB_OFF_MASK, 32'h2);
      repeat (2) @(posedge clock);
      #1 check({31'h0, irq}, 32'h1);
      rd(PCB_OFF_STAT, 32'h2);
      conclude();
   end
endmodule
`default_nettype wire
